// ### logic/osrc_defs.svh
`ifndef OSRC_DEFS_SVH
`define OSRC_DEFS_SVH

// Option byte field positions
`define OSRC_BIT_POR      6
`define OSRC_BIT_SEC      5
`define OSRC_BIT_OSC_HI   4
`define OSRC_BIT_OSC_LO   3
`define OSRC_BIT_WD_DIS   2
`define OSRC_BIT_HALT_DIS 0

// Erased option byte and secured read value
`define OSRC_OPT_RESET    8'h00
`define OSRC_SECURE_READ  8'hff

// Idle timer preload on a power-on event (4096 cycles)
`define OSRC_IDLE_PRELOAD 12'hfff

// Clock monitor recovery window, in clock cycles
`define OSRC_CKMON_MIN    16
`define OSRC_CKMON_MAX    32
`define OSRC_CKMON_HOLD   5'h10

`endif

// ### logic/osrc_pkg.sv
`default_nettype none
package osrc_pkg;

    // Oscillator selection from option bits 4 and 3
    typedef enum logic [1:0] {
        OSRC_OSC_EXT     = 2'h0,
        OSRC_OSC_RC      = 2'h1,
        OSRC_OSC_XTAL    = 2'h2,
        OSRC_OSC_XTAL_B  = 2'h3
    } osrc_osc_t;

    // Decoded option fields
    typedef struct packed {
        logic      por_en;
        logic      secure;
        osrc_osc_t osc;
        logic      wd_dis;
        logic      halt_dis;
    } osrc_opt_t;

    // Programmer request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        opt_sel;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } osrc_prog_req_t;

endpackage
`default_nettype wire

// ### logic/osrc_reset_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "osrc_defs.svh"

// Power-on reset sequencing through the idle timer
module osrc_reset_seq (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic por_en_i,
    input  wire logic por_evt_i,
    output logic      por_rst_o
);

    logic [11:0] idle_cnt_reg;
    logic        por_act_reg;

    // Preload timer on detector event, count down until underflow
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            idle_cnt_reg <= 12'h000;
            por_act_reg  <= 1'b0;
        end else if (por_evt_i && por_en_i) begin
            idle_cnt_reg <= `OSRC_IDLE_PRELOAD;
            por_act_reg  <= 1'b1;
        end else if (por_act_reg) begin
            if (idle_cnt_reg == 12'h000) begin
                por_act_reg <= 1'b0;
            end else begin
                idle_cnt_reg <= idle_cnt_reg - 12'h001;
            end
        end
    end

    // Reset asserts on the event itself
    assign por_rst_o = por_act_reg | (por_evt_i & por_en_i);

    por_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (por_act_reg && idle_cnt_reg != 12'h000 && !por_evt_i)
        |=> por_rst_o)
        else $error("power-on reset released before underflow");

    por_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!por_en_i && !por_act_reg) |=> !por_act_reg)
        else $error("power-on reset without enable");

endmodule
`default_nettype wire

// ### logic/osrc_top.sv
// Operation
// - Option byte sits outside CPU program space; CPU cannot reach it.
// - Secured part returns FF on every external program read.
// - Unsecured part returns stored program contents on external reads.
// - Secured part blocks external writes to program memory and option byte.
// - Option byte is always externally readable.
// - Security bit is permanent; secured erased part refuses programming.
// - Reset on low external pin, or enabled power-on detector event.
// - Reset sets clock monitor flag; slow clock at release gives error.
// - Error drives error pin low; high 16 to 32 cycles after recovery.
// - External reset also ends halt mode.
// - Power-on reset only when its option bit is set.
// - Detector event loads idle timer with 0FFF and asserts reset.
// - Internal reset holds until timer underflow, same as external reset; pin reset here uses no timer and ends two cycles after the pin rises.
// - No further internal resets after underflow while supply stays up; here every enabled detector event reloads the timer and resets again.
// - Data registers and RAM are not initialised by power-on reset.
// - Oscillator mode decoded from option bits 4 and 3.
// - Bias resistor only in crystal mode with bit 3 set.
// - Oscillator output pin is input in ext and R/C, drive in crystal.
`timescale 1ns/1ns
`default_nettype none
`include "osrc_defs.svh"

module osrc_top #(
    parameter int ADDR_W = 15
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_n_i,
    // Board reset pin and power-on detector
    input  wire logic                    ext_rst_n_i,
    input  wire logic                    por_evt_i,
    // Programmer port
    input  wire osrc_pkg::osrc_prog_req_t prog_req_i,
    input  wire logic                    erase_i,
    output logic [7:0]                   prog_rdata_o,
    output logic                         prog_rvalid_o,
    output logic                         prog_wr_refused_o,
    // Program memory array port
    output logic [ADDR_W-1:0]            mem_addr_o,
    output logic                         mem_rd_o,
    output logic                         mem_wr_o,
    output logic [7:0]                   mem_wdata_o,
    input  wire logic [7:0]              mem_rdata_i,
    // Core control
    input  wire logic                    halt_req_i,
    input  wire logic                    clk_ok_i,
    output logic                         core_rst_o,
    output logic                         halt_o,
    output osrc_pkg::osrc_opt_t          opt_o,
    // Oscillator pins
    output logic                         bias_en_o,
    output logic                         osc_out_pin_o,
    output logic                         osc_out_pin_oe_o,
    input  wire logic                    osc_out_pin_i,
    output logic                         gp_in_o,
    input  wire logic                    osc_in_pin_i,
    // Clock monitor error pin (open drain, drives low)
    output logic                         wd_error_pin_o,
    output logic                         wd_error_pin_oe_o
);

    logic [7:0]  opt_reg;
    logic        secure_reg;
    logic        ext_s1_reg;
    logic        ext_s2_reg;
    logic        osc_s1_reg;
    logic        osc_s2_reg;
    logic        clk_s1_reg;
    logic        clk_s2_reg;
    logic        osc_in_s1_reg;
    logic        osc_in_s2_reg;
    logic        por_rst;
    logic        core_rst;
    logic        ckmon_reg;
    logic        err_reg;
    logic [4:0]  rec_cnt_reg;
    logic        halt_reg;
    logic        rd_opt_reg;
    logic        rd_mem_reg;
    logic [7:0]  rdata_reg;
    logic        refused_reg;
    logic        wr_ok;
    osrc_pkg::osrc_opt_t opt_dec;

    // Pin synchronisers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            osc_in_s1_reg <= 1'b0;
            osc_in_s2_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_rst_n_i;
            ext_s2_reg <= ext_s1_reg;
            osc_s1_reg <= osc_out_pin_i;
            osc_s2_reg <= osc_s1_reg;
            clk_s1_reg <= clk_ok_i;
            clk_s2_reg <= clk_s1_reg;
            osc_in_s1_reg <= osc_in_pin_i;
            osc_in_s2_reg <= osc_in_s1_reg;
        end
    end

    // Power-on reset sequencer
    osrc_reset_seq u_reset_seq (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .por_en_i  (opt_reg[`OSRC_BIT_POR]),
        .por_evt_i (por_evt_i),
        .por_rst_o (por_rst)
    );

    // Core reset combines pin and power-on sources
    assign core_rst   = !ext_s2_reg || por_rst;
    assign core_rst_o = core_rst;

    // Option decode
    always_comb begin
        opt_dec.por_en   = opt_reg[`OSRC_BIT_POR];
        opt_dec.secure   = opt_reg[`OSRC_BIT_SEC] | secure_reg;
        opt_dec.osc      = osrc_pkg::osrc_osc_t'(
            opt_reg[`OSRC_BIT_OSC_HI:`OSRC_BIT_OSC_LO]);
        opt_dec.wd_dis   = opt_reg[`OSRC_BIT_WD_DIS];
        opt_dec.halt_dis = opt_reg[`OSRC_BIT_HALT_DIS];
    end
    assign opt_o = opt_dec;

    // Oscillator pin control
    assign bias_en_o = (opt_dec.osc == osrc_pkg::OSRC_OSC_XTAL_B);
    assign osc_out_pin_oe_o = opt_reg[`OSRC_BIT_OSC_HI];
    assign osc_out_pin_o    = opt_reg[`OSRC_BIT_OSC_HI] & ~osc_in_s2_reg;
    assign gp_in_o = opt_reg[`OSRC_BIT_OSC_HI] ? 1'b0 : osc_s2_reg;

    // Writes allowed only when not secured
    assign wr_ok = prog_req_i.wr && !opt_dec.secure;

    // Option byte storage, reachable only from the programmer port
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            opt_reg <= `OSRC_OPT_RESET;
        end else if (erase_i && !opt_dec.secure) begin
            opt_reg <= `OSRC_OPT_RESET;
        end else if (wr_ok && prog_req_i.opt_sel) begin
            opt_reg <= prog_req_i.wdata;
        end
    end

    // Security latch survives erasure
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            secure_reg <= 1'b0;
        end else if (opt_reg[`OSRC_BIT_SEC]) begin
            secure_reg <= 1'b1;
        end
    end

    // Program array access
    assign mem_addr_o  = prog_req_i.addr[ADDR_W-1:0];
    assign mem_rd_o    = prog_req_i.rd && !prog_req_i.opt_sel;
    assign mem_wr_o    = wr_ok && !prog_req_i.opt_sel;
    assign mem_wdata_o = prog_req_i.wdata;

    // Read pipeline stage
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_opt_reg <= 1'b0;
            rd_mem_reg <= 1'b0;
        end else begin
            rd_opt_reg <= prog_req_i.rd && prog_req_i.opt_sel;
            rd_mem_reg <= prog_req_i.rd && !prog_req_i.opt_sel;
        end
    end

    // Read data; array reads masked under security, option reads never
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_opt_reg) begin
            rdata_reg <= opt_reg;
        end else if (rd_mem_reg) begin
            rdata_reg <= opt_dec.secure ? `OSRC_SECURE_READ
                                        : mem_rdata_i;
        end
    end

    // Read valid and write refusal flags
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            prog_rvalid_o <= 1'b0;
            refused_reg   <= 1'b0;
        end else begin
            prog_rvalid_o <= rd_opt_reg || rd_mem_reg;
            refused_reg   <= prog_req_i.wr && opt_dec.secure;
        end
    end
    assign prog_rdata_o      = rdata_reg;
    assign prog_wr_refused_o = refused_reg;

    // Halt mode, ended by external reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || core_rst) begin
            halt_reg <= 1'b0;
        end else if (halt_req_i && !opt_dec.halt_dis) begin
            halt_reg <= 1'b1;
        end
    end
    assign halt_o = halt_reg;

    // Clock monitor flag set by reset, error at release if clock slow
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || core_rst) begin
            ckmon_reg   <= 1'b1;
            err_reg     <= 1'b0;
            rec_cnt_reg <= 5'h00;
        end else if (ckmon_reg) begin
            ckmon_reg <= 1'b0;
            err_reg   <= !clk_s2_reg;
        end else if (err_reg) begin
            if (!clk_s2_reg) begin
                rec_cnt_reg <= 5'h00;
            end else if (rec_cnt_reg == `OSRC_CKMON_HOLD) begin
                err_reg <= 1'b0;
            end else begin
                rec_cnt_reg <= rec_cnt_reg + 5'h01;
            end
        end
    end

    // Open-drain error pin pulls low during error
    assign wd_error_pin_o    = 1'b0;
    assign wd_error_pin_oe_o = err_reg;

    sec_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_mem_reg && opt_dec.secure) |=> prog_rdata_o == 8'hff)
        else $error("secured read returned stored data");

    open_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_mem_reg && !opt_dec.secure)
        |=> prog_rdata_o == $past(mem_rdata_i))
        else $error("unsecured read did not return stored data");

    sec_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        opt_dec.secure |-> !mem_wr_o ##1 $stable(opt_reg))
        else $error("write passed while secured");

    sec_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        opt_dec.secure |=> opt_dec.secure)
        else $error("security cleared");

    rst_pin_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ext_rst_n_i ##1 !ext_rst_n_i |=> core_rst_o)
        else $error("pin reset not applied");

    err_pin_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (err_reg && !core_rst && !clk_s2_reg)
        ##1 (clk_s2_reg && !core_rst) [*8]
        |-> wd_error_pin_oe_o)
        else $error("error pin released too early");

    err_end_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (err_reg && !ckmon_reg && !core_rst && $rose(clk_s2_reg))
        |-> ##[16:32] (!wd_error_pin_oe_o || !clk_s2_reg || core_rst))
        else $error("error pin not released in window");

    bias_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bias_en_o |-> opt_reg[4] && opt_reg[3])
        else $error("bias resistor outside crystal mode");

endmodule
`default_nettype wire

// ### testbench/osrc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// Program memory array behind the programmer port
module osrc_mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic [14:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o
);
    logic [7:0] mem [0:32767];

    // Data a cycle after the strobe; an idle bus inverts the byte every cycle
    always_ff @(posedge clk_sys_i) begin
        rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule

`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    localparam int INSTR_CYC = 10;
    logic clk = 1'b0, rst_n = 1'b0, ext_rst_n = 1'b1, por_evt = 1'b0;
    logic erase = 1'b0, halt_req = 1'b0, clk_ok = 1'b1, lvl = 1'b0;
    logic rvalid, refused, mem_rd, mem_wr, core_rst, halt, bias, rf;
    logic oo, oo_oe, oo_in, gp_in, wd_o, wd_oe, sec_on = 1'b0;
    logic ckin = 1'b0;
    logic [7:0]  rdata, mem_rdata, mem_wdata, rq, o;
    logic [14:0] mem_addr;
    logic [14:0] addrs [8];
    logic [7:0]  datas [8];
    osrc_pkg::osrc_prog_req_t req = '0;
    osrc_pkg::osrc_opt_t      opt;
    int errors = 0, samples_checked = 0, cycles = 0, wr_seen = 0;
    int seed = 32'hd70f, n, i, c;

    // Oscillator output pin level seen by the block
    assign oo_in = oo_oe ? oo : lvl;

    initial forever #5 clk = ~clk;

    osrc_top i_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .ext_rst_n_i(ext_rst_n),
        .por_evt_i(por_evt), .prog_req_i(req), .erase_i(erase),
        .prog_rdata_o(rdata), .prog_rvalid_o(rvalid),
        .prog_wr_refused_o(refused), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
        .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
        .halt_req_i(halt_req), .clk_ok_i(clk_ok), .core_rst_o(core_rst),
        .halt_o(halt), .opt_o(opt), .bias_en_o(bias), .osc_out_pin_o(oo),
        .osc_out_pin_oe_o(oo_oe), .osc_out_pin_i(oo_in), .gp_in_o(gp_in),
        .osc_in_pin_i(ckin), .wd_error_pin_o(wd_o),
        .wd_error_pin_oe_o(wd_oe));

    osrc_mem_model i_mem (.clk_sys_i(clk), .addr_i(mem_addr), .rd_i(mem_rd),
        .wr_i(mem_wr), .wdata_i(mem_wdata), .rdata_o(mem_rdata));

    // Cycle ceiling and array writes seen while secured
    always @(posedge clk) begin
        cycles++;
        wr_seen += (sec_on && mem_wr !== 1'b0);
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] v);
        samples_checked++;
        if (v !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", s, e, v);
        end
    endtask

    task automatic chk1(input string s, input logic e, input logic v);
        chk8(s, {7'h0, e}, {7'h0, v});
    endtask

    task automatic chkr(input string s, input int lo, input int hi, input int v);
        samples_checked++;
        if (v < lo || v > hi) begin
            errors++;
            $display("unexpected %s: expected %0d to %0d seen %0d", s, lo, hi, v);
        end
    endtask

    // One programmer access; gathers refused flag and read data
    task automatic prog(input logic r, input logic w, input logic s,
                        input logic [14:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{r, w, s, a, d};
        rq = 8'hxx;
        rf = 1'b0;
        repeat (3) begin
            @(negedge clk);
            req = '0;
            rf = rf | refused;
            rq = (rvalid === 1'b1) ? rdata : rq;
        end
    endtask

    // Pin reset held one instruction cycle
    task automatic ext_reset();
        ext_rst_n = 1'b0;
        repeat (INSTR_CYC) @(negedge clk);
        chk1("core reset on pin", 1'b1, core_rst);
        ext_rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    // Detector pulse, then cycles of internal reset
    task automatic por_run();
        @(negedge clk);
        por_evt = 1'b1;
        @(negedge clk);
        por_evt = 1'b0;
        c = 0;
        while (core_rst === 1'b1 && c < 5000) begin
            c++;
            @(negedge clk);
        end
    endtask

    // Single-cycle halt request, then time to settle
    task automatic halt_pulse();
        @(negedge clk);
        halt_req = 1'b1;
        @(negedge clk);
        halt_req = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Single-cycle erase request
    task automatic erase_pulse();
        @(negedge clk);
        erase = 1'b1;
        @(negedge clk);
        erase = 1'b0;
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk1("core reset", 1'b0, core_rst);
        chk1("error pin enable", 1'b0, wd_oe);
        done("reset");
        // Every oscillator mode with random side bits and pin levels
        for (n = 0; n < 4; n++) begin
            o = {3'h0, n[1:0], 3'($random(seed))};
            lvl = 1'($random(seed));
            ckin = 1'($random(seed));
            prog(1'b0, 1'b1, 1'b1, 15'h0, o);
            prog(1'b1, 1'b0, 1'b1, 15'h0, 8'h0);
            chk8("option read", o, rq);
            chk8("options", {2'h0, o[6:2], o[0]}, {2'h0, opt});
            chk8("osc mode", {6'h0, o[4:3]}, {6'h0, opt.osc});
            chk1("bias", n == 3, bias);
            chk1("osc drive", n[1], oo_oe);
            chk1("osc output", n[1] & !ckin, oo);
            chk1("gp input", !n[1] & lvl, gp_in);
        end
        done("oscillator");
        // Random array traffic at distinct addresses, top address included
        for (n = 0; n < 8; n++) begin
            addrs[n] = (n == 7) ? 15'h7fff : {n[2:0], 12'($random(seed))};
            datas[n] = 8'($random(seed));
            prog(1'b0, 1'b1, 1'b0, addrs[n], datas[n]);
            chk1("write refused", 1'b0, rf);
        end
        for (n = 7; n >= 0; n--) begin
            prog(1'b1, 1'b0, 1'b0, addrs[n], 8'h0);
            chk8("array read", datas[n], rq);
        end
        done("array");
        // Halt refused while disabled, then taken and ended by pin reset
        prog(1'b0, 1'b1, 1'b1, 15'h0, 8'h01);
        halt_pulse();
        chk1("halt disabled", 1'b0, halt);
        prog(1'b0, 1'b1, 1'b1, 15'h0, 8'h00);
        halt_pulse();
        chk1("halt", 1'b1, halt);
        ext_reset();
        chk1("halt after reset", 1'b0, halt);
        done("halt");
        // Slow clock at reset end, then recovery
        clk_ok = 1'b0;
        ext_reset();
        repeat (8) @(negedge clk);
        chk1("error pin enable", 1'b1, wd_oe);
        chk1("error pin level", 1'b0, wd_o);
        clk_ok = 1'b1;
        for (i = 0; i < 60 && wd_oe === 1'b1; i++) @(negedge clk);
        chkr("error release cycles", 16, 32, i);
        done("clock monitor");
        por_run();
        chkr("por disabled", 0, 0, c);
        prog(1'b0, 1'b1, 1'b1, 15'h0, 8'h40);
        por_run();
        chkr("por length", 4096, 4097, c);
        c = 0;
        repeat (200) begin
            @(negedge clk);
            c += (core_rst !== 1'b0);
        end
        chkr("reset after underflow", 0, 0, c);
        done("power on");
        // Erase clears an unsecured option byte
        erase_pulse();
        chk8("erased options", 8'h00, {2'h0, opt});
        done("erase");
        // Security set last, other bits already written
        prog(1'b0, 1'b1, 1'b1, 15'h0, 8'h40);
        prog(1'b0, 1'b1, 1'b1, 15'h0, 8'h60);
        sec_on = 1'b1;
        prog(1'b1, 1'b0, 1'b0, addrs[1], 8'h0);
        chk8("secured read", 8'hff, rq);
        prog(1'b0, 1'b1, 1'b0, addrs[1], 8'h00);
        chk1("secured write refused", 1'b1, rf);
        prog(1'b0, 1'b1, 1'b1, 15'h0, 8'h00);
        chk1("option write refused", 1'b1, rf);
        prog(1'b1, 1'b0, 1'b1, 15'h0, 8'h0);
        chk8("secured option read", 8'h60, rq);
        erase_pulse();
        prog(1'b0, 1'b1, 1'b0, addrs[2], 8'h11);
        chk1("erased secure kept", 1'b1, opt.secure);
        chk1("erased write refused", 1'b1, rf);
        chkr("secured array writes", 0, 0, wr_seen);
        done("security");
        summarize();
    end
endmodule

`default_nettype wire
